// File: design/au_arith_unit.sv
// arithmetic unit: multiply / divide over axi4-lite
//
// Notes on behaviour
// - 16x16 multiply, 32/16 and 16/16 divide
// - data access while busy sets error flag
// - status read when idle clears error
// - overflow on product over ffff or zero divisor
// - overflow rewritten at every completion
// - status bits 5..0 zero, flags read-only
// - write of byte 5 ends sequence, starts only after writes 0..4, 0,1,4 or 0,4,1
// - reads and non-data writes between writes are harmless
// - writes 0..5 select 32/16 divide
// - writes 0,1,4,5 select 16/16 divide
// - writes 0,4,1,5 select multiply
// - 17, 9 or 11 cycles of calculation
// - 32/16 results: quotient 0..3, remainder 4..5
// - 16/16 results: quotient 0..1, remainder 4..5
// - product in bytes 0..3
// - reads may be interleaved with anything
// - byte 0 least significant
`timescale 1ns/1ps
module au_arith_unit
   import au_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [AU_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AU_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // register index decode
   function automatic logic [2:0] reg_index(input logic [AU_ADDR_W-1:0] addr);
      logic [2:0] idx;
      idx = 3'h7;
      unique case ({{(32-AU_ADDR_W){1'b0}}, addr[AU_ADDR_W-1:2], 2'b00})
         AU_OFS_BYTE0: idx = 3'h0;
         AU_OFS_BYTE1: idx = 3'h1;
         AU_OFS_BYTE2: idx = 3'h2;
         AU_OFS_BYTE3: idx = 3'h3;
         AU_OFS_BYTE4: idx = 3'h4;
         AU_OFS_BYTE5: idx = 3'h5;
         AU_OFS_STATUS: idx = 3'h6;
         default: idx = 3'h7;
      endcase
      return idx;
   endfunction

   // true for the six operand/result bytes
   function automatic logic is_data(input logic [2:0] idx);
      return idx < 3'h6;
   endfunction

   // calculation length of an operation
   function automatic logic [4:0] op_cycles(input au_op_e kind);
      logic [4:0] n;
      n = AU_CNT_MUL;
      unique case (kind)
         AU_OP_DIV32: n = AU_CNT_DIV32;
         AU_OP_DIV16: n = AU_CNT_DIV16;
         AU_OP_MUL: n = AU_CNT_MUL;
         default: n = AU_CNT_MUL;
      endcase
      return n;
   endfunction

   logic [7:0] data_reg [AU_NUM_DATA];
   logic busy;
   logic [4:0] busy_cnt;
   au_op_e op;
   au_seq_e seq;
   logic err_flag;
   logic ovf_flag;
   logic aw_held;
   logic w_held;
   logic [AU_ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic [2:0] rd_idx;
   logic [2:0] wr_idx;
   logic wr_fire;
   logic rd_fire;
   logic start;
   au_op_e next_op;
   au_seq_e next_seq;
   logic data_wr;
   logic [7:0] rd_byte;
   logic [7:0] status_byte;
   logic ovf_next;

   ////////////////////////////////////////////////////////////////////////////
   // axi write channel: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = reg_index(aw_addr);
   // accepted operand write: lane 0, idle, data byte
   assign data_wr = wr_fire && w_lane0 && !busy && is_data(wr_idx);

   // write address holder
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   // write data holder
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
   end

   // write response, slverr off the map
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AU_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_idx == 3'h7) ? AU_RESP_SLVERR : AU_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_idx = reg_index(s_axi_araddr);
   assign status_byte = {err_flag, ovf_flag, 6'h00};

   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_idx)
         3'h0: rd_byte = data_reg[0];
         3'h1: rd_byte = data_reg[1];
         3'h2: rd_byte = data_reg[2];
         3'h3: rd_byte = data_reg[3];
         3'h4: rd_byte = data_reg[4];
         3'h5: rd_byte = data_reg[5];
         3'h6: rd_byte = status_byte;
         3'h7: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= AU_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (rd_idx == 3'h7) ? AU_RESP_SLVERR : AU_RESP_OKAY;
         s_axi_rdata <= {24'h000000, rd_byte};
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequence tracker
   always_comb begin
      next_seq = seq;
      next_op = op;
      start = 1'b0;
      if (data_wr) begin
         next_seq = (wr_idx == 3'h0) ? AU_SEQ_W0 : AU_SEQ_IDLE;
         unique case (seq)
            AU_SEQ_IDLE: ;
            AU_SEQ_W0: begin
               if (wr_idx == 3'h1) begin
                  next_seq = AU_SEQ_W01;
               end
               if (wr_idx == 3'h4) begin
                  next_seq = AU_SEQ_W04;
               end
            end
            AU_SEQ_W01: begin
               if (wr_idx == 3'h2) begin
                  next_seq = AU_SEQ_W012;
               end
               if (wr_idx == 3'h4) begin
                  next_seq = AU_SEQ_W014;
               end
            end
            AU_SEQ_W012: begin
               if (wr_idx == 3'h3) begin
                  next_seq = AU_SEQ_W0123;
               end
            end
            AU_SEQ_W0123: begin
               if (wr_idx == 3'h4) begin
                  next_seq = AU_SEQ_W01234;
               end
            end
            AU_SEQ_W04: begin
               if (wr_idx == 3'h1) begin
                  next_seq = AU_SEQ_W041;
               end
            end
            AU_SEQ_W01234, AU_SEQ_W014, AU_SEQ_W041: begin
               if (wr_idx == 3'h5) begin
                  start = 1'b1;
                  next_seq = AU_SEQ_IDLE;
                  next_op = (seq == AU_SEQ_W01234) ? AU_OP_DIV32 :
                            (seq == AU_SEQ_W014) ? AU_OP_DIV16 : AU_OP_MUL;
               end
            end
         endcase
      end
   end

   // only data writes move the tracker
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq <= AU_SEQ_IDLE;
         op <= AU_OP_DIV32;
      end else begin
         seq <= next_seq;
         op <= next_op;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         busy_cnt <= 5'h00;
      end else if (start) begin
         busy <= 1'b1;
         busy_cnt <= op_cycles(next_op);
      end else if (busy) begin
         busy_cnt <= busy_cnt - 5'h01;
         if (busy_cnt == 5'h01) begin
            busy <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operands and results
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic [31:0] quotient;
   logic [15:0] remainder;
   logic [31:0] product;
   logic finish;

   assign dividend = (op == AU_OP_DIV32) ? {data_reg[3], data_reg[2], data_reg[1], data_reg[0]} :
                     {16'h0000, data_reg[1], data_reg[0]};
   assign divisor = {data_reg[5], data_reg[4]};
   assign quotient = (divisor == 16'h0000) ? 32'hffffffff : dividend / {16'h0000, divisor};
   assign remainder = (divisor == 16'h0000) ? dividend[15:0] : 16'((dividend % {16'h0000, divisor}));
   assign product = {data_reg[1], data_reg[0]} * {data_reg[5], data_reg[4]};
   assign finish = busy && busy_cnt == 5'h01;

   logic [31:0] result_lo;
   logic [15:0] result_hi;

   always_comb begin
      result_lo = product;
      result_hi = {data_reg[5], data_reg[4]};
      unique case (op)
         AU_OP_MUL: begin
            result_lo = product;
            result_hi = {data_reg[5], data_reg[4]};
         end
         AU_OP_DIV32, AU_OP_DIV16: begin
            result_lo = quotient;
            result_hi = remainder;
         end
         default: begin
            result_lo = product;
            result_hi = {data_reg[5], data_reg[4]};
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < AU_NUM_DATA; i++) begin
            data_reg[i] <= AU_DATA_RESET;
         end
      end else if (finish) begin
         {data_reg[3], data_reg[2], data_reg[1], data_reg[0]} <= result_lo;
         {data_reg[5], data_reg[4]} <= result_hi;
      end else if (data_wr) begin
         data_reg[wr_idx] <= w_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags
   logic data_touch;
   assign data_touch = (wr_fire && is_data(wr_idx)) || (rd_fire && is_data(rd_idx));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_flag <= 1'b0;
      end else if (busy && data_touch) begin
         err_flag <= 1'b1;
      end else if (rd_fire && rd_idx == 3'h6 && !busy) begin
         err_flag <= 1'b0;
      end
   end

   always_comb begin
      ovf_next = 1'b0;
      unique case (op)
         AU_OP_MUL: ovf_next = product[31:16] != 16'h0000;
         AU_OP_DIV32, AU_OP_DIV16: ovf_next = divisor == 16'h0000;
         default: ovf_next = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_flag <= 1'b0;
      end else if (finish) begin
         ovf_flag <= ovf_next;
      end
   end

endmodule

// File: design/au_pkg.sv
// constants for the arithmetic unit
package au_pkg;
   localparam logic [31:0] AU_OFS_BYTE0 = 32'h00000000;
   localparam logic [31:0] AU_OFS_BYTE1 = 32'h00000004;
   localparam logic [31:0] AU_OFS_BYTE2 = 32'h00000008;
   localparam logic [31:0] AU_OFS_BYTE3 = 32'h0000000c;
   localparam logic [31:0] AU_OFS_BYTE4 = 32'h00000010;
   localparam logic [31:0] AU_OFS_BYTE5 = 32'h00000014;
   localparam logic [31:0] AU_OFS_STATUS = 32'h00000018;
   localparam int AU_NUM_DATA = 6;
   localparam int AU_ADDR_W = 5;
   localparam int AU_BIT_ERR = 7;
   localparam int AU_BIT_OVF = 6;
   localparam logic [7:0] AU_DATA_RESET = 8'h00;
   localparam logic [1:0] AU_RESP_OKAY = 2'h0;
   localparam logic [1:0] AU_RESP_SLVERR = 2'h2;
   // calculation times in system clock periods
   localparam int AU_TIME_DIV32 = 17;
   localparam int AU_TIME_DIV16 = 9;
   localparam int AU_TIME_MUL = 11;
   localparam logic [4:0] AU_CNT_DIV32 = 5'(AU_TIME_DIV32);
   localparam logic [4:0] AU_CNT_DIV16 = 5'(AU_TIME_DIV16);
   localparam logic [4:0] AU_CNT_MUL = 5'(AU_TIME_MUL);
   typedef enum logic [1:0] {AU_OP_DIV32, AU_OP_DIV16, AU_OP_MUL} au_op_e;
   typedef enum {AU_SEQ_IDLE, AU_SEQ_W0, AU_SEQ_W01, AU_SEQ_W012, AU_SEQ_W0123, AU_SEQ_W01234,
                 AU_SEQ_W014, AU_SEQ_W04, AU_SEQ_W041} au_seq_e;
endpackage

// File: dv/au_arith_unit_monitor.sv
// bus-side checker for the arithmetic unit
`timescale 1ns/1ps
module au_arith_unit_monitor
   import au_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [AU_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AU_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] ra;
   logic [2:0] wa;
   ////////////////////////////////////////////////////////////////
   // word index of the transfer being answered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ra <= 3'h0;
         wa <= 3'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr[4:2];
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr[4:2];
      end
   end
   ////////////////////////////////////////////////////////////////
   arready_free_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready not inverse of rvalid");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
   status_zero_a: assert property (s_axi_rvalid && ra == 3'h6 |-> s_axi_rdata[5:0] == 6'h0)
      else $error("status low bits set");
   rresp_map_a: assert property (s_axi_rvalid |-> s_axi_rresp == (ra == 3'h7 ? AU_RESP_SLVERR : AU_RESP_OKAY))
      else $error("wrong read response");
   bresp_map_a: assert property (s_axi_bvalid |-> s_axi_bresp == (wa == 3'h7 ? AU_RESP_SLVERR : AU_RESP_OKAY))
      else $error("wrong write response");
endmodule
bind au_arith_unit au_arith_unit_monitor i_au_arith_unit_monitor (.*);

// File: dv/au_arith_unit_tb.sv
// self-checking bench for the arithmetic unit
`timescale 1ns/1ps
module au_arith_unit_tb
   import au_pkg::*;
;
   logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [AU_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   au_arith_unit i_au_arith_unit (.*);
   always #2.5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////
   task wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] r);
      logic ad, dd;
      ad = 0;
      dd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ad && dd)) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) ad = 1;
         if (s_axi_wvalid && s_axi_wready) dd = 1;
         if (ad) s_axi_awvalid <= 0;
         if (dd) s_axi_wvalid <= 0;
      end
      do @(posedge core_clk); while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task rd(input logic [4:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      rd(5'h18);
      chk(d, 32'h0);
      rd(5'h1c);
      chk(d, 32'h0);
      wr(5'h1c, 8'h5a, AU_RESP_SLVERR);
   endtask
   // k: 0 divide 32/16, 1 divide 16/16, 2 multiply; p pokes data while busy
   task t_op(input int k, input logic [31:0] a, input logic [15:0] b, input logic p);
      logic [47:0] e;
      logic [23:0] sq;
      logic [7:0] o [6];
      logic ov;
      int n, j;
      o = '{a[7:0], a[15:8], a[23:16], a[31:24], b[7:0], b[15:8]};
      sq = k == 0 ? 24'h012345 : (k == 1 ? 24'h000145 : 24'h000415);
      n = k == 0 ? 6 : 4;
      for (int i = 0; i < n; i++) begin
         j = sq[4*(n-1-i) +: 4];
         wr(5'(4*j), o[j], AU_RESP_OKAY);
         if (i == 1) rd(5'h18);
      end
      if (p) wr(5'h00, 8'haa, AU_RESP_OKAY);
      if (p) rd(5'h04);
      repeat (k == 0 ? AU_TIME_DIV32 : (k == 1 ? AU_TIME_DIV16 : AU_TIME_MUL)) @(posedge core_clk);
      e[31:0] = b == 0 ? 32'hffffffff : (k == 0 ? a / b : a[15:0] / b);
      e[47:32] = b == 0 ? a[15:0] : (k == 0 ? 16'(a % b) : a[15:0] % b);
      if (k == 2) e = {16'h0, 32'(a[15:0]) * b};
      ov = k == 2 ? e[31:16] != 0 : b == 0;
      rd(5'h18);
      chk(d, {24'h0, p, ov, 6'h0});
      sq = k == 0 ? 24'h012345 : (k == 1 ? 24'h000145 : 24'h000123);
      for (int i = 0; i < n; i++) begin
         j = sq[4*(n-1-i) +: 4];
         rd(5'(4*j));
         chk(d, {24'h0, e[8*j +: 8]});
         if (i == 1) rd(5'h18);
         if (i == 1) chk(d, {24'h0, 1'b0, ov, 6'h0});
      end
      rd(5'h18);
      chk(d, {24'h0, 1'b0, ov, 6'h0});
   endtask
   // touch byte 0 at the last busy edge, or one edge later
   task t_edge(input int late);
      wr(5'h00, 8'h03, AU_RESP_OKAY);
      wr(5'h10, 8'h05, AU_RESP_OKAY);
      wr(5'h04, 8'h00, AU_RESP_OKAY);
      wr(5'h14, 8'h00, AU_RESP_OKAY);
      repeat (AU_TIME_MUL - 2 + late) @(posedge core_clk);
      rd(5'h00);
      rd(5'h18);
      chk(d, {24'h0, late == 0, 7'h0});
   endtask
   task t_broken;
      wr(5'h00, 8'h11, AU_RESP_OKAY);
      wr(5'h08, 8'h22, AU_RESP_OKAY);
      wr(5'h04, 8'h33, AU_RESP_OKAY);
      wr(5'h14, 8'h44, AU_RESP_OKAY);
      rd(5'h08);
      chk(d, 32'h22);
      rd(5'h18);
      chk(d, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      t_reset;
      t_op(0, 32'h12345678, 16'h1234, 0);
      t_op(1, 32'h0000beef, 16'h0011, 0);
      t_op(2, 32'h00001234, 16'h5678, 0);
      t_op(2, 32'h000000ff, 16'h0100, 1);
      t_op(1, 32'h00001234, 16'h0000, 0);
      t_op(0, 32'hffffffff, 16'h0001, 0);
      t_op(0, 32'h00000000, 16'h0000, 1);
      t_op(2, 32'h0000ffff, 16'h0001, 0);
      t_broken;
      t_op(1, 32'h0000fffe, 16'h00ff, 0);
      t_edge(0);
      t_edge(1);
      final_report;
   end
endmodule
